// >>> rtl/interrupt_priority_resolver.sv
/*
  Interrupt priority resolver: gathers the non-maskable, debug, external and
  peripheral requests, ranks them by level, fixed or programmed, and default order, and
  offers the winner to the processor core. Priority registers, the event code
  register and a status word sit on an AXI4-Lite slave.
  Assumes requests are levels held by their sources until serviced, peripheral
  requests come from logic on mclk, and pins are asynchronous.
*/
`include "intc_defines.svh"
`default_nettype none

module interrupt_priority_resolver
  import intc_pkg::*;
(
  input  wire logic        mclk,            // Peripheral clock, 50 MHz.
  input  wire logic        rst_b,           // Synchronous reset, active low.
  input  wire logic        ce,              // Clock enable; low freezes all state.
  input  wire logic        nmi_pin,         // Non-maskable request pin, high = request.
  input  wire logic [7:0]  ext_irq_b,       // External request pins, low = request.
  input  wire logic        debug_port_irq,  // Debug port request.
  input  wire logic        dma_done_0,      // DMA channel 0 done.
  input  wire logic        dma_done_1,      // DMA channel 1 done.
  input  wire logic        dma_done_2,      // DMA channel 2 done.
  input  wire logic        dma_done_3,      // DMA channel 3 done.
  input  wire logic        uart0_rx_error,  // Serial port 0 receive error.
  input  wire logic        uart0_rx_full,   // Serial port 0 receive data full.
  input  wire logic        uart0_break,     // Serial port 0 break.
  input  wire logic        uart0_tx_empty,  // Serial port 0 transmit empty.
  input  wire logic        uart1_rx_error,  // Serial port 1 receive error.
  input  wire logic        uart1_rx_full,   // Serial port 1 receive data full.
  input  wire logic        uart1_break,     // Serial port 1 break.
  input  wire logic        uart1_tx_empty,  // Serial port 1 transmit empty.
  input  wire logic        adc0_done,       // Converter 0 done.
  input  wire logic        adc1_done,       // Converter 1 done.
  input  wire logic        usb_irq_0,       // USB request 0.
  input  wire logic        usb_irq_1,       // USB request 1.
  input  wire logic        usb_irq_high,    // USB high-priority request.
  input  wire logic [3:0]  cpu_mask_level,  // Core's current mask level.
  input  wire logic        cpu_accept,      // Core takes the offered request.
  output logic             irq_req,         // Request to the core, level.
  output logic [4:0]       irq_level,       // Level of the offered request.
  output logic [11:0]      irq_code,        // Code of the offered request.
  output logic [11:0]      event_code,      // Contents of event_code_reg.
  input  wire logic [7:0]  awaddr,          // Write address.
  input  wire logic [2:0]  awprot,          // Write protection, unused.
  input  wire logic        awvalid,         // Write address valid.
  output logic             awready,         // Write address ready.
  input  wire logic [31:0] wdata,           // Write data.
  input  wire logic [3:0]  wstrb,           // Write byte strobes.
  input  wire logic        wvalid,          // Write data valid.
  output logic             wready,          // Write data ready.
  output logic [1:0]       bresp,           // Write response.
  output logic             bvalid,          // Write response valid.
  input  wire logic        bready,          // Write response ready.
  input  wire logic [7:0]  araddr,          // Read address.
  input  wire logic [2:0]  arprot,          // Read protection, unused.
  input  wire logic        arvalid,         // Read address valid.
  output logic             arready,         // Read address ready.
  output logic [31:0]      rdata,           // Read data.
  output logic [1:0]       rresp,           // Read response.
  output logic             rvalid,          // Read data valid.
  input  wire logic        rready           // Read data ready.
);

  state_t state_q;
  state_t state_d;
  prio_if pi ();

  logic [7:0]  ext_req;
  logic        nmi_req;
  logic [15:0] per_req;
  logic [7:0]  wr_addr;
  logic [7:0]  rd_addr;
  logic        wr_go;
  logic        rd_go;

  // Peripheral requests are levels on mclk and are not latched here: a
  // source that drops its request before it is taken simply disappears.

  // Byte-lane merge of a write into a 16-bit register; upper lanes drop.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = data[7:0];
    end
    if (strb[1]) begin
      r[15:8] = data[15:8];
    end
    return r;
  endfunction

  // True when an aligned address hits a mapped register.
  function automatic logic mapped(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'h0};
    return w == `ADDR_PRIO_C || w == `ADDR_PRIO_D || w == `ADDR_PRIO_E ||
           w == `ADDR_PRIO_F || w == `ADDR_PRIO_J || w == `ADDR_EVENT_CODE ||
           w == `ADDR_STATUS;
  endfunction

  // Pins are used only after the second synchroniser stage.
  assign nmi_req = state_q.pin_s2[8];
  assign ext_req = ~state_q.pin_s2[7:0];
  assign per_req = {usb_irq_high, usb_irq_1, usb_irq_0, adc1_done, adc0_done,
                    uart1_tx_empty, uart1_break, uart1_rx_full, uart1_rx_error,
                    uart0_tx_empty, uart0_break, uart0_rx_full, uart0_rx_error,
                    dma_done_3, dma_done_2, dma_done_1};

  // Requests in default order; each slot carries its level.
  always_comb begin
    pi.req = {per_req, dma_done_0, ext_req, debug_port_irq, nmi_req};
    pi.level = '0;
    pi.level[`IDX_NMI]   = `LVL_NMI;
    pi.level[`IDX_DEBUG] = `LVL_DEBUG;
    for (int i = 0; i < 4; i++) begin
      pi.level[`IDX_EXT0 + i]     = {1'b0, state_q.prio_c[4*i +: 4]};
      pi.level[`IDX_EXT0 + 4 + i] = {1'b0, state_q.prio_d[4*i +: 4]};
      pi.level[`IDX_DMA0 + i]     = {1'b0, state_q.prio_j[12-4*i +: 4]};
      pi.level[`IDX_UART0 + i]    = {1'b0, state_q.prio_e[11:8]};
      pi.level[`IDX_UART1 + i]    = {1'b0, state_q.prio_e[7:4]};
    end
    pi.level[`IDX_ADC0] = {1'b0, state_q.prio_e[3:0]};
    pi.level[`IDX_ADC1] = {1'b0, state_q.prio_f[15:12]};
    for (int i = 0; i < 3; i++) begin
      pi.level[`IDX_USB0 + i] = {1'b0, state_q.prio_f[7:4]};
    end
  end

  // The search itself is purely combinational; its result is registered in
  // the state below, so the core sees a winner one edge after the requests
  // settle. A deeper pipeline would ease timing but delay every offer.
  prio_resolver prio_resolver_i (
    .pi (pi)
  );

  // Bus handshakes; a captured address or data blocks its channel.
  assign awready = !state_q.aw_have;
  assign wready  = !state_q.w_have;
  assign arready = !state_q.rvalid;
  assign wr_addr = {state_q.aw_addr[7:2], 2'h0};
  assign rd_addr = {araddr[7:2], 2'h0};
  assign wr_go   = state_q.aw_have && state_q.w_have && !state_q.bvalid;
  assign rd_go   = arvalid && !state_q.rvalid;

  // Next state: synchronisers, winner, event code and bus slave.
  always_comb begin
    state_d = state_q;
    state_d.pin_s1 = {nmi_pin, ext_irq_b};
    state_d.pin_s2 = state_q.pin_s1;

    // The winner is ranked afresh each cycle, so an unaccepted request is
    // replaced as soon as a stronger one appears.
    state_d.req  = pi.win_valid && (pi.win_level > {1'b0, cpu_mask_level});
    state_d.lvl  = pi.win_level;
    state_d.nmi  = pi.win_idx == `IDX_NMI;
    state_d.code = code_of(pi.win_idx);

    // Only the request that was on offer is loaded; an offer with no code
    // leaves the register as it was.
    if (cpu_accept && state_q.req && !state_q.nmi) begin
      state_d.evt = state_q.code;
    end

    if (awvalid && !state_q.aw_have) begin
      state_d.aw_have = 1'b1;
      state_d.aw_addr = awaddr;
    end
    if (wvalid && !state_q.w_have) begin
      state_d.w_have = 1'b1;
      state_d.w_data = wdata;
      state_d.w_strb = wstrb;
    end
    if (state_q.bvalid && bready) begin
      state_d.bvalid = 1'b0;
    end

    // Write once both halves are held and the last response has gone.
    if (wr_go) begin
      state_d.aw_have = 1'b0;
      state_d.w_have  = 1'b0;
      state_d.bvalid  = 1'b1;
      state_d.bresp   = mapped(state_q.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
      case (wr_addr)
        `ADDR_PRIO_C: state_d.prio_c = merge16(state_q.prio_c, state_q.w_data, state_q.w_strb);
        `ADDR_PRIO_D: state_d.prio_d = merge16(state_q.prio_d, state_q.w_data, state_q.w_strb);
        `ADDR_PRIO_E: state_d.prio_e = merge16(state_q.prio_e, state_q.w_data, state_q.w_strb);
        `ADDR_PRIO_F: state_d.prio_f = merge16(state_q.prio_f, state_q.w_data, state_q.w_strb);
        `ADDR_PRIO_J: state_d.prio_j = merge16(state_q.prio_j, state_q.w_data, state_q.w_strb);
        default: begin
        end
      endcase
    end

    if (state_q.rvalid && rready) begin
      state_d.rvalid = 1'b0;
    end
    // Read data are captured at the address handshake and held until taken.
    if (rd_go) begin
      state_d.rvalid = 1'b1;
      state_d.rresp  = mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      state_d.rdata  = '0;
      case (rd_addr)
        `ADDR_PRIO_C:     state_d.rdata[15:0] = state_q.prio_c;
        `ADDR_PRIO_D:     state_d.rdata[15:0] = state_q.prio_d;
        `ADDR_PRIO_E:     state_d.rdata[15:0] = state_q.prio_e;
        `ADDR_PRIO_F:     state_d.rdata[15:0] = state_q.prio_f;
        `ADDR_PRIO_J:     state_d.rdata[15:0] = state_q.prio_j;
        `ADDR_EVENT_CODE: state_d.rdata[11:0] = state_q.evt;
        `ADDR_STATUS: begin
          state_d.rdata[`STAT_LVL_LSB +: 5]   = state_q.lvl;
          state_d.rdata[`STAT_REQ_BIT]        = state_q.req;
          state_d.rdata[`STAT_CODE_LSB +: 12] = state_q.code;
        end
        default: begin
        end
      endcase
    end
  end

  // Reset clears every priority field, masking all programmable sources.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // Outputs from the state register; the level reads zero when nothing is offered.
  assign irq_req    = state_q.req;
  assign irq_level  = state_q.req ? state_q.lvl : `LVL_MASKED;
  assign irq_code   = state_q.code;
  assign event_code = state_q.evt;
  assign bvalid     = state_q.bvalid;
  assign bresp      = state_q.bresp;
  assign rvalid     = state_q.rvalid;
  assign rresp      = state_q.rresp;
  assign rdata      = state_q.rdata;

endmodule

`default_nettype wire

// >>> rtl/intc_defines.svh
/*
  Constants of the interrupt priority resolver: register offsets, source
  indices in default order, event codes, fixed levels and bus responses.
  Assumes inclusion by bare name from the package and the top module.
*/
`ifndef INTC_DEFINES_SVH
`define INTC_DEFINES_SVH

// Register byte offsets on the AXI4-Lite slave.
`define ADDR_PRIO_C      8'h00
`define ADDR_PRIO_D      8'h04
`define ADDR_PRIO_E      8'h08
`define ADDR_PRIO_F      8'h0c
`define ADDR_PRIO_J      8'h10
`define ADDR_EVENT_CODE  8'h14
`define ADDR_STATUS      8'h18

// Reset value of every priority register: all programmable sources masked.
`define PRIO_RESET       16'h0000

// Status register field positions.
`define STAT_LVL_LSB     0
`define STAT_REQ_BIT     8
`define STAT_CODE_LSB    16

// Source indices; a lower index wins a tie in level.
`define SRC_COUNT        27
`define IDX_NMI          5'h00
`define IDX_DEBUG        5'h01
`define IDX_EXT0         5'h02
`define IDX_DMA0         5'h0a
`define IDX_UART0        5'h0e
`define IDX_UART1        5'h12
`define IDX_ADC0         5'h16
`define IDX_ADC1         5'h17
`define IDX_USB0         5'h18

// Event codes; neighbours in a group step by 0x20.
`define CODE_NONE        12'h000
`define CODE_DEBUG       12'h5e0
`define CODE_EXT0        12'h600
`define CODE_DMA0        12'h800
`define CODE_USB0        12'ha00
`define CODE_STEP_LOG2   5

// Fixed levels.
`define LVL_NMI          5'h10
`define LVL_DEBUG        5'h0f
`define LVL_MASKED       5'h00

// AXI response codes.
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// >>> rtl/intc_pkg.sv
/*
  Types and the event code lookup of the interrupt priority resolver.
  Assumes the defines header is on the include path.
*/
`include "intc_defines.svh"
`default_nettype none

package intc_pkg;

  typedef logic [4:0]  lvl_t;
  typedef logic [4:0]  idx_t;
  typedef logic [11:0] code_t;

  // Whole state of the top module, registered in one place.
  typedef struct packed {
    logic [8:0]  pin_s1;
    logic [8:0]  pin_s2;
    logic [15:0] prio_c;
    logic [15:0] prio_d;
    logic [15:0] prio_e;
    logic [15:0] prio_f;
    logic [15:0] prio_j;
    code_t       evt;
    logic        req;
    logic        nmi;
    lvl_t        lvl;
    code_t       code;
    logic        aw_have;
    logic [7:0]  aw_addr;
    logic        w_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } state_t;

  // Event code of a source index; the non-maskable source has none.
  function automatic code_t code_of(input idx_t i);
    code_t c;
    c = `CODE_NONE;
    if (i == `IDX_DEBUG) begin
      c = `CODE_DEBUG;
    end else if (i >= `IDX_EXT0 && i < `IDX_DMA0) begin
      c = `CODE_EXT0 + (code_t'(i - `IDX_EXT0) << `CODE_STEP_LOG2);
    end else if (i >= `IDX_DMA0 && i < `IDX_USB0) begin
      c = `CODE_DMA0 + (code_t'(i - `IDX_DMA0) << `CODE_STEP_LOG2);
    end else if (i >= `IDX_USB0) begin
      c = `CODE_USB0 + (code_t'(i - `IDX_USB0) << `CODE_STEP_LOG2);
    end
    return c;
  endfunction

endpackage

`default_nettype wire

// >>> rtl/prio_if.sv
/*
  Carrier between the top module and the priority resolver: requests with
  their levels one way, the winner the other way.
  Assumes the package is compiled first.
*/
`include "intc_defines.svh"
`default_nettype none

interface prio_if;
  import intc_pkg::*;

  logic [`SRC_COUNT-1:0]       req;
  lvl_t [`SRC_COUNT-1:0]       level;
  logic                        win_valid;
  idx_t                        win_idx;
  lvl_t                        win_level;

  modport resolver (input req, input level, output win_valid, output win_idx, output win_level);
  modport owner (output req, output level, input win_valid, input win_idx, input win_level);
endinterface

`default_nettype wire

// >>> rtl/prio_resolver.sv
/*
  Combinational search for the pending source of highest level.
  Assumes sources are indexed in default order, index 0 first.
*/
`include "intc_defines.svh"
`default_nettype none

module prio_resolver
  import intc_pkg::*;
(
  prio_if.resolver pi  // Requests in, winner out.
);

  // Only a strictly higher level displaces the current best, so level 0
  // never wins and a tie keeps the earlier source in default order.
  always_comb begin
    pi.win_valid = 1'b0;
    pi.win_idx   = `IDX_NMI;
    pi.win_level = `LVL_MASKED;
    for (int i = 0; i < `SRC_COUNT; i++) begin
      if (pi.req[i] && pi.level[i] > pi.win_level) begin
        pi.win_valid = 1'b1;
        pi.win_idx   = idx_t'(i);
        pi.win_level = pi.level[i];
      end
    end
  end

endmodule

`default_nettype wire

// >>> test/intc_props.sv
/*
  Concurrent checks on the interrupt priority resolver's ports.
  Assumes it is bound to the top module and that ce is held high.
*/
`default_nettype none

module intc_props (
  input wire logic        mclk,            // Peripheral clock.
  input wire logic        rst_b,           // Synchronous reset, active low.
  input wire logic [3:0]  cpu_mask_level,  // Core mask level.
  input wire logic        cpu_accept,      // Core take pulse.
  input wire logic        irq_req,         // Offer to the core.
  input wire logic [4:0]  irq_level,       // Offered level.
  input wire logic [11:0] irq_code,        // Offered code.
  input wire logic [11:0] event_code,      // Event code register.
  input wire logic        awvalid,         // Write address valid.
  input wire logic        awready,         // Write address ready.
  input wire logic        wvalid,          // Write data valid.
  input wire logic        wready,          // Write data ready.
  input wire logic        bvalid,          // Write response valid.
  input wire logic        arvalid,         // Read address valid.
  input wire logic        arready,         // Read address ready.
  input wire logic        rvalid           // Read data valid.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // The offer tracks the mask one edge late, so the past mask is the reference.
  property p_above_mask; irq_req |-> irq_level > {1'b0, $past(cpu_mask_level)}; endproperty
  a_above_mask: assert property (p_above_mask) else $error("offer not above mask");
  property p_idle_level; !irq_req |-> irq_level == 5'h00; endproperty
  a_idle_level: assert property (p_idle_level) else $error("level shown without offer");
  property p_range; irq_level <= 5'h10; endproperty
  a_range: assert property (p_range) else $error("level above sixteen");
  property p_nmi_level; irq_req && irq_code == 12'h000 |-> irq_level == 5'h10; endproperty
  a_nmi_level: assert property (p_nmi_level) else $error("non-maskable offer not at sixteen");
  property p_debug_level; irq_req && irq_code == 12'h5e0 |-> irq_level == 5'h0f; endproperty
  a_debug_level: assert property (p_debug_level) else $error("debug offer not at fifteen");

  // The event code changes only when the core takes a coded offer.
  property p_load; cpu_accept && irq_req && irq_code != 12'h000 |=> event_code == $past(irq_code); endproperty
  a_load: assert property (p_load) else $error("event code not loaded");
  property p_hold; !(cpu_accept && irq_req) |=> $stable(event_code); endproperty
  a_hold: assert property (p_hold) else $error("event code changed");

  // A read answers one edge after its address is taken; a write first holds
  // both halves for one edge and answers at the edge after that.
  property p_rd_ans; arvalid && arready |=> rvalid && !arready; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_wr_ans; awvalid && awready && wvalid && wready |-> ##2 bvalid; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");

  c_nmi: cover property (irq_req && irq_level == 5'h10);
  c_take: cover property (cpu_accept && irq_req);
  c_write: cover property (bvalid);
endmodule

`default_nettype wire

// >>> test/cpu_core_model.sv
/*
  Behavioural processor core on the far side of the resolver.
  Assumes the resolver offers a level request and reads a one-cycle take.
*/
`default_nettype none

module cpu_core_model (
  input  wire logic       mclk,        // Peripheral clock.
  input  wire logic       rst_b,       // Synchronous reset, active low.
  input  wire logic       en,          // Takes requests while high.
  input  wire logic [3:0] gap,         // Cycles to the next instruction boundary.
  input  wire logic       irq_req,     // Offer from the resolver.
  output logic            cpu_accept,  // One-cycle take pulse.
  output int              taken        // Takes so far.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;

  // A take lands only at an instruction boundary; a long gap lets the
  // resolver re-rank while the core is still busy.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cpu_accept <= 1'b0;
      wait_q     <= 4'h0;
      taken      <= 0;
    end else if (cpu_accept) begin
      cpu_accept <= 1'b0;
    end else if (en && irq_req && wait_q >= gap) begin
      cpu_accept <= 1'b1;
      wait_q     <= 4'h0;
      taken      <= taken + 1;
    end else begin
      wait_q <= irq_req ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule

`default_nettype wire

// >>> test/interrupt_priority_resolver_test.sv
/*
  Self-checking bench of the interrupt priority resolver with a core model.
  Assumes the package, carrier and design are compiled first.
*/
`default_nettype none

module interrupt_priority_resolver_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk, rst_b, awvalid, wvalid, bready, arvalid, rready, en;
  logic        irq_req, cpu_accept, awready, wready, bvalid, arready, rvalid;
  logic [26:0] src;
  logic [3:0]  mask, gap;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, resp;
  logic [4:0]  irq_level;
  logic [11:0] irq_code, event_code;
  logic [23:0] rows [2:26];
  int          taken, n_mismatch, num_checks, cycles;

  // Bit n of src is source n in default order; external pins are active low.
  interrupt_priority_resolver interrupt_priority_resolver_i (.mclk(mclk), .rst_b(rst_b), .ce(1'b1),
    .nmi_pin(src[0]), .ext_irq_b(~src[9:2]), .debug_port_irq(src[1]), .dma_done_0(src[10]),
    .dma_done_1(src[11]), .dma_done_2(src[12]), .dma_done_3(src[13]), .uart0_rx_error(src[14]),
    .uart0_rx_full(src[15]), .uart0_break(src[16]), .uart0_tx_empty(src[17]), .uart1_rx_error(src[18]),
    .uart1_rx_full(src[19]), .uart1_break(src[20]), .uart1_tx_empty(src[21]), .adc0_done(src[22]),
    .adc1_done(src[23]), .usb_irq_0(src[24]), .usb_irq_1(src[25]), .usb_irq_high(src[26]),
    .cpu_mask_level(mask), .cpu_accept(cpu_accept), .irq_req(irq_req), .irq_level(irq_level),
    .irq_code(irq_code), .event_code(event_code), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  cpu_core_model cpu_core_model_i (.mclk(mclk), .rst_b(rst_b), .en(en), .gap(gap), .irq_req(irq_req),
    .cpu_accept(cpu_accept), .taken(taken));

  // Clock and hang guard; the run needs well under ten thousand cycles.
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Ready is read at the falling edge so the value is the one the next rising edge sees.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge mclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while ((awvalid && !ta) || (wvalid && !tw));
    do begin
      @(negedge mclk);
      ta   = bvalid;
      resp = bresp;
      @(posedge mclk);
    end while (!ta);
    bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    logic tk;
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge mclk);
      tk = arready;
      @(posedge mclk);
    end while (!tk);
    arvalid <= 1'b0;
    do begin
      @(negedge mclk);
      tk   = rvalid;
      rd   = rdata;
      resp = rresp;
      @(posedge mclk);
    end while (!tk);
    rready <= 1'b0;
  endtask

  // Pins need three edges to reach the offer, so four are given.
  task automatic drive(input logic [26:0] s, input logic [3:0] m);
    @(posedge mclk);
    src  <= s;
    mask <= m;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic expect_irq(input logic r, input logic [4:0] l, input logic [11:0] c);
    check(32'(irq_req), 32'(r));
    check(32'(irq_level), 32'(l));
    if (r) check(32'(irq_code), 32'(c));
  endtask

  // Lets the core take the current offer once, when its pending-cycle count is at least g.
  task automatic take(input logic [3:0] g);
    int n;
    n = taken;
    @(posedge mclk);
    en  <= 1'b1;
    gap <= g;
    for (int k = 0; k < 40 && taken == n; k++) @(posedge mclk);
    en <= 1'b0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    check(32'(taken - n), 32'h1);
  endtask

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready, en} = 7'h00;
    {src, mask, gap, awaddr, araddr, wdata} = '0;
    {n_mismatch, num_checks, cycles} = '0;
    // Row: register offset, field shift, event code.
    rows = '{24'h000600, 24'h004620, 24'h008640, 24'h00c660, 24'h040680, 24'h0446a0, 24'h0486c0,
      24'h04c6e0, 24'h10c800, 24'h108820, 24'h104840, 24'h100860, 24'h088880, 24'h0888a0, 24'h0888c0,
      24'h0888e0, 24'h084900, 24'h084920, 24'h084940, 24'h084960, 24'h080980, 24'h0cc9a0, 24'h0c4a00,
      24'h0c4a20, 24'h0c4a40};
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    // Each programmable source alone: silent at level 0, then offered at its field's level.
    for (int i = 2; i <= 26; i++) begin
      drive(27'h1 << i, 4'h0);
      expect_irq(1'b0, 5'h00, 12'h000);
      wr(rows[i][23:16], 32'((i % 15 + 1) << rows[i][15:12]));
      rd_reg(rows[i][23:16]);
      check(rd, 32'((i % 15 + 1) << rows[i][15:12]));
      drive(27'h1 << i, 4'h0);
      expect_irq(1'b1, 5'(i % 15 + 1), rows[i][11:0]);
      wr(rows[i][23:16], 32'h0);
    end
    $display("Test source table done");
    // Equal levels on every programmable source: peel sources off in default order.
    for (int a = 0; a <= 16; a += 4) wr(8'(a), 32'h00005555);
    for (int i = 0; i <= 26; i++) begin
      drive(27'h7ffffff << i, 4'h4);
      expect_irq(1'b1, i == 0 ? 5'h10 : i == 1 ? 5'h0f : 5'h05,
                 i == 0 ? 12'h000 : i == 1 ? 12'h5e0 : rows[i][11:0]);
    end
    $display("Test default order done");
    // Mask boundaries: offered only strictly above the core's mask.
    drive(27'h1 << 15, 4'h4);
    expect_irq(1'b1, 5'h05, 12'h8a0);
    drive(27'h1 << 15, 4'h5);
    expect_irq(1'b0, 5'h00, 12'h000);
    drive(27'h2, 4'hf);
    expect_irq(1'b0, 5'h00, 12'h000);
    drive(27'h1, 4'hf);
    expect_irq(1'b1, 5'h10, 12'h000);
    $display("Test mask done");
    // A higher request displaces a pending lower one, which comes back after.
    wr(8'h0c, 32'h00000030);
    wr(8'h10, 32'h00009000);
    drive(27'h1 << 24, 4'h0);
    expect_irq(1'b1, 5'h03, 12'ha00);
    drive((27'h1 << 24) | (27'h1 << 10), 4'h0);
    expect_irq(1'b1, 5'h09, 12'h800);
    drive(27'h1 << 24, 4'h0);
    expect_irq(1'b1, 5'h03, 12'ha00);
    // Takes with gaps of 5 then 0 load the code; other offers leave it alone.
    take(4'h5);
    drive(27'h1 << 26, 4'h0);
    check(32'(event_code), 32'h00000a00);
    take(4'h0);
    check(32'(event_code), 32'h00000a40);
    drive(27'h1, 4'h0);
    take(4'h0);
    check(32'(event_code), 32'h00000a40);
    // The code and status words read back over the bus: the offer is non-maskable.
    rd_reg(8'h14);
    check(rd, 32'h00000a40);
    rd_reg(8'h18);
    check(rd, 32'h00000110);
    $display("Test take done");
    // Reset in mid-run clears every level; unmapped offsets are refused.
    drive(27'h0, 4'h0);
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    @(negedge mclk);
    check(32'(event_code), 32'h0);
    for (int a = 0; a <= 16; a += 4) begin
      rd_reg(8'(a));
      check(rd, 32'h0);
    end
    rd_reg(8'h1c);
    check(32'(resp), 32'h2);
    wr(8'h1c, 32'h0000ffff);
    check(32'(resp), 32'h2);
    $display("Test reset and refusal done");
    final_report();
  end
endmodule

bind interrupt_priority_resolver intc_props intc_props_i (.mclk(mclk), .rst_b(rst_b),
  .cpu_mask_level(cpu_mask_level), .cpu_accept(cpu_accept), .irq_req(irq_req), .irq_level(irq_level),
  .irq_code(irq_code), .event_code(event_code), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bvalid(bvalid), .arvalid(arvalid), .arready(arready), .rvalid(rvalid));

`default_nettype wire
